// File: common/ide_bus_pkg.sv
package ide_bus_pkg;

   // Special function register address of the high data byte
   localparam logic [7:0] HIGH_DATA_ADDR = 8'hF9;

   // Reset value chosen for the high data byte (the hardware leaves it undefined)
   localparam logic [7:0] HIGH_DATA_RESET = 8'h00;

   // Bus cycle phase lengths in CPU clock periods
   localparam int ADDR_CYCLES    = 2;
   localparam int STROBE_CYCLES  = 3;
   localparam int STRETCH_CYCLES = 15;
   localparam int RECOVER_CYCLES = 1;
   localparam int BUS_CYCLES     = ADDR_CYCLES + STROBE_CYCLES + RECOVER_CYCLES;

   // Phase counter width and preloads
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] ADDR_LOAD    = CNT_W'(ADDR_CYCLES - 1);
   localparam logic [CNT_W-1:0] STROBE_LOAD  = CNT_W'(STROBE_CYCLES - 1);
   localparam logic [CNT_W-1:0] STRETCH_LOAD = CNT_W'(STRETCH_CYCLES - 1);
   localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYCLES - 1);

   // Idle and drive levels of the active-low pins and enables
   localparam logic STROBE_IDLE = 1'b1;
   localparam logic OE_RELEASE  = 1'b1;
   localparam logic OE_DRIVE    = 1'b0;

   // Bus cycle sequencer states
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_ADDR    = 4'b0010,
      ST_STROBE  = 4'b0100,
      ST_RECOVER = 4'b1000
   } bus_state_e;

endpackage

// File: core/ide_sixteen_bit_external_bus.sv
`timescale 1ns/100ps
module ide_sixteen_bit_external_bus #(
   parameter int DEPTH = 2,
   parameter int WIDTH = 16
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        wide_access_enable,
   input  wire logic        strobe_stretch,
   input  wire logic        page_access_mode_bit,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic        req_indirect,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic [7:0]  port_two_sfr,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_write,
   input  wire logic [7:0]  sfr_wdata,
   output logic [7:0]       sfr_rdata,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [7:0]       rd_acc_data,
   output logic [7:0]       rd_high_data,
   output logic             xfer_done,
   output logic [7:0]       port_zero_out,
   input  wire logic [7:0]  port_zero_in,
   output logic             port_zero_oe_n,
   output logic [7:0]       port_two_out,
   input  wire logic [7:0]  port_two_in,
   output logic             port_two_oe_n,
   output logic             address_latch_strobe,
   output logic             read_strobe_n,
   output logic             write_strobe_n
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_F = $clog2(DEPTH + 1);

   ide_bus_pkg::bus_state_e          state_reg;
   ide_bus_pkg::bus_state_e          state_next;
   logic [ide_bus_pkg::CNT_W-1:0]    cnt_reg;
   logic [ide_bus_pkg::CNT_W-1:0]    cnt_next;
   logic                             start;
   logic                             phase_end;
   logic                             wr_q;
   logic                             wide_q;
   logic                             stretch_q;
   logic [7:0]                       lo_data_q;
   logic [7:0]                       hi_data_q;
   logic [7:0]                       hi_addr_sel;
   logic [7:0]                       high_data_byte_reg;
   logic [7:0]                       p0_meta;
   logic [7:0]                       p0_sync;
   logic [7:0]                       p2_meta;
   logic [7:0]                       p2_sync;
   logic [WIDTH-1:0]                 mem [DEPTH];
   logic [PTR_W-1:0]                 wr_ptr_reg;
   logic [PTR_W-1:0]                 rd_ptr_reg;
   logic [CNT_F-1:0]                 count_reg;
   logic                             push;
   logic                             pop;
   logic                             fifo_room;

   // Reads need a free buffer slot before starting, so a stalled receiver holds off the bus
   assign fifo_room = (count_reg < CNT_F'(DEPTH));
   assign req_ready = (state_reg == ide_bus_pkg::ST_IDLE) && (req_write || fifo_room);
   assign start     = req_valid && req_ready;
   assign phase_end = (cnt_reg == '0);

   // High address source: port register for indirect or paged forms, else pointer high byte
   always_comb begin
      if (req_indirect) begin
         hi_addr_sel = port_two_sfr;
      end else if (page_access_mode_bit) begin
         hi_addr_sel = port_two_sfr;
      end else begin
         hi_addr_sel = req_addr[15:8];
      end
   end

   // Sequencer: address phase, strobe phase, recovery; 2+3+1 clocks normally
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg - 1'b1;
      unique case (state_reg)
         ide_bus_pkg::ST_IDLE: begin
            cnt_next = ide_bus_pkg::ADDR_LOAD;
            if (start) begin
               state_next = ide_bus_pkg::ST_ADDR;
            end
         end
         ide_bus_pkg::ST_ADDR: begin
            if (phase_end) begin
               state_next = ide_bus_pkg::ST_STROBE;
               // Stretch widens only the strobe phase
               cnt_next   = stretch_q ? ide_bus_pkg::STRETCH_LOAD : ide_bus_pkg::STROBE_LOAD;
            end
         end
         ide_bus_pkg::ST_STROBE: begin
            if (phase_end) begin
               state_next = ide_bus_pkg::ST_RECOVER;
               cnt_next   = ide_bus_pkg::RECOVER_LOAD;
            end
         end
         ide_bus_pkg::ST_RECOVER: begin
            if (phase_end) begin
               state_next = ide_bus_pkg::ST_IDLE;
               cnt_next   = ide_bus_pkg::ADDR_LOAD;
            end
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ide_bus_pkg::ST_IDLE;
         cnt_reg   <= ide_bus_pkg::ADDR_LOAD;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Request capture; mode bits are frozen per cycle so a mid-cycle change cannot tear it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q      <= 1'b0;
         wide_q    <= 1'b0;
         stretch_q <= 1'b0;
         lo_data_q <= 8'h00;
         hi_data_q <= 8'h00;
      end else if (start) begin
         wr_q      <= req_write;
         wide_q    <= wide_access_enable;
         stretch_q <= strobe_stretch;
         lo_data_q <= acc_wdata;
         hi_data_q <= high_data_byte_reg;
      end
   end

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         p0_meta <= 8'h00;
         p0_sync <= 8'h00;
         p2_meta <= 8'h00;
         p2_sync <= 8'h00;
      end else begin
         p0_meta <= port_zero_in;
         p0_sync <= p0_meta;
         p2_meta <= port_two_in;
         p2_sync <= p2_meta;
      end
   end

   // Port drive: address in the address phase, then write data or release for read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         port_zero_out  <= 8'h00;
         port_zero_oe_n <= ide_bus_pkg::OE_RELEASE;
         port_two_out   <= 8'h00;
         port_two_oe_n  <= ide_bus_pkg::OE_RELEASE;
      end else if (start) begin
         port_zero_out  <= req_addr[7:0];
         port_zero_oe_n <= ide_bus_pkg::OE_DRIVE;
         port_two_out   <= hi_addr_sel;
         port_two_oe_n  <= ide_bus_pkg::OE_DRIVE;
      end else if (state_reg == ide_bus_pkg::ST_ADDR && phase_end) begin
         if (wr_q) begin
            port_zero_out <= lo_data_q;
            if (wide_q) begin
               port_two_out <= hi_data_q;
            end
         end else begin
            port_zero_oe_n <= ide_bus_pkg::OE_RELEASE;
            // Narrow reads keep the high address on port_two
            port_two_oe_n  <= wide_q ? ide_bus_pkg::OE_RELEASE : ide_bus_pkg::OE_DRIVE;
         end
      end else if (state_reg == ide_bus_pkg::ST_RECOVER && phase_end) begin
         // Write data held through recovery, past the strobe's rising edge
         port_zero_oe_n <= ide_bus_pkg::OE_RELEASE;
         port_two_oe_n  <= ide_bus_pkg::OE_RELEASE;
      end
   end

   // Latch strobe and active-low read and write strobes, registered to stay glitch free
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         address_latch_strobe <= 1'b0;
         read_strobe_n        <= ide_bus_pkg::STROBE_IDLE;
         write_strobe_n       <= ide_bus_pkg::STROBE_IDLE;
      end else begin
         address_latch_strobe <= start;
         read_strobe_n        <= !(state_next == ide_bus_pkg::ST_STROBE && !wr_q);
         write_strobe_n       <= !(state_next == ide_bus_pkg::ST_STROBE && wr_q);
      end
   end

   // Read data taken on the last strobe clock, then buffered for the accumulator
   assign push = (state_reg == ide_bus_pkg::ST_STROBE) && phase_end && !wr_q;
   assign pop  = rd_valid && rd_ready;

   // High data byte; a completing wide read wins over a same-cycle software write
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         high_data_byte_reg <= ide_bus_pkg::HIGH_DATA_RESET;
      end else if (push && wide_q) begin
         high_data_byte_reg <= p2_sync;
      end else if (sfr_write && sfr_addr == ide_bus_pkg::HIGH_DATA_ADDR) begin
         high_data_byte_reg <= sfr_wdata;
      end
   end

   // Register read port, one clock latency; other addresses read zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= (sfr_addr == ide_bus_pkg::HIGH_DATA_ADDR) ? high_data_byte_reg : 8'h00;
      end
   end

   // End of bus cycle pulse
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= (state_reg == ide_bus_pkg::ST_RECOVER) && phase_end;
      end
   end

   // Read buffer storage; narrow reads return zero as high byte
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= {(wide_q ? p2_sync : 8'h00), p0_sync};
      end
   end

   // Read buffer pointers and occupancy
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Buffer head to the accumulator side
   assign rd_valid     = (count_reg != '0);
   assign rd_acc_data  = mem[rd_ptr_reg][7:0];
   assign rd_high_data = mem[rd_ptr_reg][15:8];

endmodule

// File: verif/ide_bus_asserts.sv
`timescale 1ns/100ps
// Pin-level protocol checks on the external bus
module ide_bus_asserts (
   input logic mclk,
   input logic sys_rst,
   input logic req_valid,
   input logic req_ready,
   input logic strobe_stretch,
   input logic xfer_done,
   input logic port_zero_oe_n,
   input logic address_latch_strobe,
   input logic read_strobe_n,
   input logic write_strobe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [4:0] low_cnt_reg;
   // Strobe widths exceed a repetition count, so a counter measures them
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) low_cnt_reg <= 5'h00;
      else if (!read_strobe_n || !write_strobe_n) low_cnt_reg <= low_cnt_reg + 5'h01;
      else low_cnt_reg <= 5'h00;
   end
   a_strobe_width: assert property (($rose(read_strobe_n) || $rose(write_strobe_n)) |->
      low_cnt_reg == (strobe_stretch ? 5'h0F : 5'h03)) else $error("strobe width wrong");
   a_ale_pulse: assert property (address_latch_strobe |=> !address_latch_strobe)
      else $error("latch strobe longer than one cycle");
   a_ale_leads: assert property (($fell(read_strobe_n) || $fell(write_strobe_n)) |->
      $past(address_latch_strobe, 2)) else $error("strobe without latch pulse before it");
   a_one_strobe: assert property (!(!read_strobe_n && !write_strobe_n))
      else $error("both strobes active");
   a_write_drive: assert property (!write_strobe_n |-> !port_zero_oe_n)
      else $error("write data not driven");
   a_read_release: assert property (!read_strobe_n |-> port_zero_oe_n)
      else $error("low port driven during read");
   // Done is registered off the last recovery clock, so it is seen on the seventh edge after acceptance
   a_cycle_len: assert property ((req_valid && req_ready && !strobe_stretch) |=>
      !xfer_done [*6] ##1 xfer_done) else $error("bus cycle length wrong");
   a_done_pulse: assert property (xfer_done |=> !xfer_done)
      else $error("done pulse too long");
   a_busy_ready: assert property (address_latch_strobe |-> !req_ready)
      else $error("request taken mid cycle");
endmodule
bind ide_sixteen_bit_external_bus ide_bus_asserts chk (.mclk, .sys_rst, .req_valid, .req_ready, .strobe_stretch,
   .xfer_done, .port_zero_oe_n, .address_latch_strobe, .read_strobe_n, .write_strobe_n);

// File: verif/ide_disk_model.sv
`timescale 1ns/100ps
// Behavioural disk: latches the address, stores written words, answers reads
module ide_disk_model (
   input logic        mclk,
   input logic        address_latch_strobe,
   input logic [7:0]  port_zero_out,
   input logic [7:0]  port_two_out,
   input logic        read_strobe_n,
   input logic        write_strobe_n,
   output logic [7:0] port_zero_in,
   output logic [7:0] port_two_in
);
   logic [15:0] mem [256];
   logic [7:0]  lat_lo;
   logic [7:0]  lat_hi;
   logic [15:0] last = 16'h0000;
   // External latch takes both address bytes during the pulse
   always @(posedge mclk) if (address_latch_strobe) {lat_hi, lat_lo} <= {port_two_out, port_zero_out};
   // Word taken as the strobe rises, while the bus still holds it
   always @(posedge write_strobe_n) mem[lat_lo] <= {port_two_out, port_zero_out};
   // Released bus flips every cycle so stale data never looks valid
   always @(posedge mclk) last <= {port_two_in, port_zero_in};
   assign {port_two_in, port_zero_in} = !read_strobe_n ? mem[lat_lo] : ~last;
endmodule

// File: verif/ide_sixteen_bit_external_bus_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module ide_sixteen_bit_external_bus_tb;
   logic mclk, sys_rst, wide_access_enable, strobe_stretch, page_access_mode_bit, req_valid, req_ready, req_write;
   logic req_indirect, rd_valid, rd_ready, xfer_done, port_zero_oe_n, port_two_oe_n, address_latch_strobe;
   logic read_strobe_n, write_strobe_n, sfr_write;
   logic [15:0] req_addr, a;
   logic [7:0] acc_wdata, port_two_sfr, sfr_addr, sfr_wdata, sfr_rdata, rd_acc_data, rd_high_data;
   logic [7:0] port_zero_out, port_zero_in, port_two_out, port_two_in, lo, hi, d0, d1, hb, lo2, hi2;
   logic [2:0] m;
   int n_fail = 0, n_checks = 0, seed = 34407, n0, n1, nbase;
   ide_sixteen_bit_external_bus uut (.*);
   ide_disk_model model (.*);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Issues one bus cycle and counts edges from acceptance to completion
   task automatic req(input logic w, ind, wd, st, pg, input logic [15:0] ad, input logic [7:0] d, output int n);
      @(posedge mclk);
      {req_write, req_indirect, wide_access_enable, strobe_stretch, page_access_mode_bit} <= {w, ind, wd, st, pg};
      req_addr <= ad;
      acc_wdata <= d;
      req_valid <= 1'b1;
      @(posedge mclk);
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(posedge mclk);
      req_valid <= 1'b0;
      for (n = 0; n < 50 && xfer_done !== 1'b1; n++) @(posedge mclk);
   endtask
   task automatic pop(output logic [7:0] l, h);
      @(posedge mclk);
      rd_ready <= 1'b1;
      @(posedge mclk);
      for (int k = 0; k < 50 && rd_valid !== 1'b1; k++) @(posedge mclk);
      {h, l} = {rd_high_data, rd_acc_data};
      rd_ready <= 1'b0;
   endtask
   task automatic hset(input logic [7:0] v);
      @(posedge mclk);
      {sfr_addr, sfr_wdata, sfr_write} <= {ide_bus_pkg::HIGH_DATA_ADDR, v, 1'b1};
      @(posedge mclk);
      sfr_write <= 1'b0;
   endtask
   task automatic hget(input logic [7:0] ad, output logic [7:0] v);
      @(posedge mclk);
      sfr_addr <= ad;
      repeat (2) @(posedge mclk);
      v = sfr_rdata;
   endtask
   // Upper address byte the latch should see for a given pointer form
   function automatic logic [7:0] exp_hi(input logic ind, pg, input logic [15:0] ad);
      return (ind || pg) ? port_two_sfr : ad[15:8];
   endfunction
   task automatic end_sim;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #(50 * 40000);
      n_fail++;
      end_sim();
   end
   initial begin
      {req_valid, req_write, req_indirect, wide_access_enable, strobe_stretch, page_access_mode_bit} = 6'h00;
      {sfr_write, rd_ready, req_addr, acc_wdata, port_two_sfr, sfr_addr, sfr_wdata} = 42'h0;
      sys_rst = 1'b1;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      hget(ide_bus_pkg::HIGH_DATA_ADDR, hb);
      `CHK(hb, ide_bus_pkg::HIGH_DATA_RESET)
      hget(8'h80, hb);
      `CHK(hb, 8'h00)
      req(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 8'h00, nbase);
      pop(lo, hi);
      for (int i = 0; i < 12; i++) begin
         {a, d0, d1, m} = {$random(seed), $random(seed)};
         @(posedge mclk);
         port_two_sfr <= $random(seed);
         hset(d1);
         req(1'b1, m[0], 1'b1, m[1], m[2], a, d0, n0);
         `CHK({model.lat_hi, model.lat_lo}, {exp_hi(m[0], m[2], a), a[7:0]})
         `CHK(n0, nbase + (m[1] ? 12 : 0))
         req(1'b0, m[0], 1'b1, m[1], m[2], a, 8'h00, n1);
         pop(lo, hi);
         `CHK({hi, lo}, {d1, d0})
         hget(ide_bus_pkg::HIGH_DATA_ADDR, hb);
         `CHK(hb, d1)
         req(1'b0, m[0], 1'b0, m[1], m[2], a, 8'h00, n1);
         pop(lo, hi);
         `CHK({hi, lo}, {8'h00, d0})
         req(1'b1, m[0], 1'b0, 1'b0, m[2], a, ~d0, n1);
         req(1'b0, m[0], 1'b1, 1'b0, m[2], a, 8'h00, n1);
         pop(lo, hi);
         `CHK({hi, lo}, {exp_hi(m[0], m[2], a), ~d0})
      end
      // Fill the read buffer, check refusal, then drain in order
      hset(8'hC3);
      req(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0010, 8'h3C, n1);
      req(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0011, 8'hA5, n1);
      req(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0010, 8'h00, n1);
      req(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0011, 8'h00, n1);
      `CHK(req_ready, 1'b0)
      pop(lo, hi);
      pop(lo2, hi2);
      `CHK({hi, lo, hi2, lo2}, 32'hC33CC3A5)
      end_sim();
   end
endmodule
